// ### adc_fmt_pkg.sv
`default_nettype none
package adc_fmt_pkg;
  localparam int CODE_W = 8;
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;

  // latencies in sample-clock cycles, counted between falling edges
  localparam int LAT_PRIMARY = 13;
  localparam int LAT_DELAYED = 14;
  localparam int LAT_DDR_DEMUX_EXTRA = 1;
  localparam int PIPE_DEPTH = LAT_DELAYED + LAT_DDR_DEMUX_EXTRA;

  localparam logic [APB_ADDR_W-1:0] CFG_OFFSET = 12'h000;
  localparam logic [APB_ADDR_W-1:0] FS_ADJ_OFFSET = 12'h004;
  localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 12'h008;

  localparam int CFG_W = 5;
  localparam int CFG_REG_CTRL_BIT = 0;
  localparam int CFG_DDR_BIT = 1;
  localparam int CFG_EDGE_DEMUX_BIT = 2;
  localparam int CFG_SWING_BIT = 3;
  localparam int CFG_DCC_BIT = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h18;

  localparam int FS_ADJ_W = 9;
  localparam logic [FS_ADJ_W-1:0] FS_ADJ_RESET = 9'h100;
  localparam logic [FS_ADJ_W-1:0] FS_PIN_HIGH_CODE = 9'h1FF;
  localparam logic [FS_ADJ_W-1:0] FS_PIN_LOW_CODE = 9'h000;

  localparam int STAT_DEMUX_BIT = 0;
  localparam int STAT_DDR_BIT = 1;
  localparam int STAT_LAUNCH_RISE_BIT = 2;
  localparam int STAT_REG_CTRL_BIT = 3;
  localparam int STAT_OOR_STICKY_BIT = 4;

  localparam logic [CODE_W-1:0] CODE_MIN = 8'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;

  // pin synchroniser vector layout
  localparam int PIN_W = 25;
  localparam int PIN_SCLK = 24;
  localparam int PIN_I_LSB = 16;
  localparam int PIN_Q_LSB = 8;
  localparam int PIN_I_UNDER = 7;
  localparam int PIN_I_OVER = 6;
  localparam int PIN_Q_UNDER = 5;
  localparam int PIN_Q_OVER = 4;
  localparam int PIN_EDGE = 3;
  localparam int PIN_FLOAT = 2;
  localparam int PIN_RANGE = 1;
  localparam int PIN_SWING = 0;

  typedef struct packed {
    logic oor;
    logic [CODE_W-1:0] q;
    logic [CODE_W-1:0] i;
  } sample_word_t;
endpackage
`default_nettype wire

// ### sample_pipe_if.sv
`default_nettype none
interface sample_pipe_if;
  import adc_fmt_pkg::*;
  logic shift;
  sample_word_t din;
  sample_word_t tap_primary;
  sample_word_t tap_delayed;
  sample_word_t tap_extra;
  modport feeder (output shift, output din,
                  input tap_primary, input tap_delayed, input tap_extra);
  modport line (input shift, input din,
                output tap_primary, output tap_delayed, output tap_extra);
endinterface
`default_nettype wire

// ### sample_delay_line.sv
`default_nettype none
module sample_delay_line #(
  parameter int DEPTH = adc_fmt_pkg::PIPE_DEPTH
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  sample_pipe_if.line pipe
);
  import adc_fmt_pkg::*;

  sample_word_t stage_q [DEPTH];
  sample_word_t stage_d [DEPTH];

  // advances only when pipe.shift is set, holds otherwise
  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      stage_d[k] = stage_q[k];
    end
    if (pipe.shift) begin
      stage_d[0] = pipe.din;
      for (int k = 1; k < DEPTH; k++) begin
        stage_d[k] = stage_q[k-1];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < DEPTH; k++) begin
        stage_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < DEPTH; k++) begin
        stage_q[k] <= stage_d[k];
      end
    end
  end

  // stage k holds the sample taken k+1 edges ago
  assign pipe.tap_primary = stage_q[LAT_PRIMARY-1];
  assign pipe.tap_delayed = stage_q[LAT_DELAYED-1];
  assign pipe.tap_extra = stage_q[DEPTH-1];

  property p_shift_moves;
    @(posedge clk_i) disable iff (!arst_n_i)
    pipe.shift |=> stage_q[1] == $past(stage_q[0]);
  endproperty
  a_shift_moves: assert property (p_shift_moves)
    else $error("delay line did not advance");
endmodule
`default_nettype wire

// ### dual_adc_output_formatter.sv
`default_nettype none
// Summary of operation
// - demux primary bus shows sample 13 old
// - demux delayed bus shows sample 14 old
// - non-demux: delayed buses off, primary 13 old
// - data launched on sample clock fall
// - SDR pin: high rising, grounded falling
// - config bit: edge in SDR, demux in DDR
// - DDR clock zero phase to data
// - demux DDR adds one extra cycle
// - SDR clock equals bus word rate
// - DDR clock half rate, both edges
// - floating edge pin selects DDR
// - range pin sets range, both channels
// - register mode uses full-scale adjust
// - swing from pin or bit, low reduced
// - duty-cycle correction enabled by default
// - forwarded clock drives data latching
// - DDR config bit one non-demux, zero demux
// - out of range flags, code clamped
// - offset binary, eight bits per channel
// - demux half rate, non-demux full rate
module dual_adc_output_formatter (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [adc_fmt_pkg::APB_ADDR_W-1:0] paddr_i,
  input wire logic [adc_fmt_pkg::APB_DATA_W-1:0] pwdata_i,
  output logic [adc_fmt_pkg::APB_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_clk_i,
  input wire logic [adc_fmt_pkg::CODE_W-1:0] i_code_i,
  input wire logic [adc_fmt_pkg::CODE_W-1:0] q_code_i,
  input wire logic i_under_i,
  input wire logic i_over_i,
  input wire logic q_under_i,
  input wire logic q_over_i,
  input wire logic launch_edge_select_pin_i,
  input wire logic launch_edge_float_i,
  input wire logic range_select_pin_i,
  input wire logic swing_select_pin_i,
  output logic forwarded_output_clock_o,
  output logic [adc_fmt_pkg::CODE_W-1:0] i_primary_bus_o,
  output logic [adc_fmt_pkg::CODE_W-1:0] q_primary_bus_o,
  output logic [adc_fmt_pkg::CODE_W-1:0] i_delayed_bus_o,
  output logic [adc_fmt_pkg::CODE_W-1:0] q_delayed_bus_o,
  output logic delayed_bus_oe_o,
  output logic out_of_range_o,
  output logic range_high_o,
  output logic [adc_fmt_pkg::FS_ADJ_W-1:0] full_scale_code_o,
  output logic swing_normal_o,
  output logic dcc_enable_o
);
  import adc_fmt_pkg::*;

  function automatic logic [CODE_W-1:0] clamp_code(
    input logic [CODE_W-1:0] code,
    input logic under,
    input logic over
  );
    logic [CODE_W-1:0] res;
    res = code;
    if (under) begin
      res = CODE_MIN;
    end else if (over) begin
      res = CODE_MAX;
    end
    return res;
  endfunction

  function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] a);
    return (a == CFG_OFFSET) || (a == FS_ADJ_OFFSET) ||
           (a == STATUS_OFFSET);
  endfunction

  sample_pipe_if pipe ();

  sample_delay_line #(
    .DEPTH(PIPE_DEPTH)
  ) u_delay (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pipe(pipe.line)
  );

  // pin synchroniser; sync1 is only read by sync2
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic sclk_prev_q, sclk_prev_d;

  assign pins = {sample_clk_i, i_code_i, q_code_i, i_under_i, i_over_i,
                 q_under_i, q_over_i, launch_edge_select_pin_i,
                 launch_edge_float_i, range_select_pin_i,
                 swing_select_pin_i};

  always_comb begin
    sync1_d = pins;
    sync2_d = sync1_q;
    sclk_prev_d = sync2_q[PIN_SCLK];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  // APB slave and registers
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [FS_ADJ_W-1:0] fs_adj_q, fs_adj_d;
  logic oor_sticky_q, oor_sticky_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [APB_DATA_W-1:0] prdata_q, prdata_d;
  logic setup_ph, write_done;
  logic [APB_DATA_W-1:0] status_word;

  // mode decode
  logic reg_ctrl, ddr, demux, ddr_demux, launch_rising;
  logic samp_fall, samp_rise, word_ev, mid_ev;
  logic oor_set, phase_q, phase_d;

  always_comb begin
    reg_ctrl = cfg_q[CFG_REG_CTRL_BIT];
    ddr = reg_ctrl ? cfg_q[CFG_DDR_BIT] : sync2_q[PIN_FLOAT];
    // non-demux only reachable in DDR under register control
    demux = reg_ctrl ? ~(ddr & cfg_q[CFG_EDGE_DEMUX_BIT]) : 1'b1;
    ddr_demux = ddr & demux;
    launch_rising = ~ddr & (reg_ctrl ? cfg_q[CFG_EDGE_DEMUX_BIT]
                                     : sync2_q[PIN_EDGE]);
  end

  always_comb begin
    samp_fall = sclk_prev_q & ~sync2_q[PIN_SCLK];
    samp_rise = ~sclk_prev_q & sync2_q[PIN_SCLK];
    // demux emits one word per two samples, non-demux one per sample
    word_ev = samp_fall & (~demux | phase_q);
    mid_ev = ~ddr & (demux ? (samp_fall & ~phase_q) : samp_rise);
  end

  always_comb begin
    status_word = '0;
    status_word[STAT_DEMUX_BIT] = demux;
    status_word[STAT_DDR_BIT] = ddr;
    status_word[STAT_LAUNCH_RISE_BIT] = launch_rising;
    status_word[STAT_REG_CTRL_BIT] = reg_ctrl;
    status_word[STAT_OOR_STICKY_BIT] = oor_sticky_q;
  end

  always_comb begin
    setup_ph = psel_i & ~penable_i & ~pready_q;
    write_done = psel_i & penable_i & pready_q & pwrite_i & reg_hit(paddr_i);
    cfg_d = cfg_q;
    fs_adj_d = fs_adj_q;
    pready_d = setup_ph;
    pslverr_d = setup_ph ? ~reg_hit(paddr_i) : 1'b0;
    prdata_d = '0;
    if (setup_ph && !pwrite_i) begin
      if (paddr_i == CFG_OFFSET) begin
        prdata_d = APB_DATA_W'(cfg_q);
      end else if (paddr_i == FS_ADJ_OFFSET) begin
        prdata_d = APB_DATA_W'(fs_adj_q);
      end else if (paddr_i == STATUS_OFFSET) begin
        prdata_d = status_word;
      end
    end
    if (write_done && paddr_i == CFG_OFFSET) begin
      cfg_d = pwdata_i[CFG_W-1:0];
    end
    if (write_done && paddr_i == FS_ADJ_OFFSET) begin
      fs_adj_d = pwdata_i[FS_ADJ_W-1:0];
    end
    // write-one-to-clear; a new overrange in the same cycle wins
    oor_sticky_d = oor_sticky_q;
    if (write_done && paddr_i == STATUS_OFFSET &&
        pwdata_i[STAT_OOR_STICKY_BIT]) begin
      oor_sticky_d = 1'b0;
    end
    if (oor_set) begin
      oor_sticky_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= CFG_RESET;
      fs_adj_q <= FS_ADJ_RESET;
      oor_sticky_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      fs_adj_q <= fs_adj_d;
      oor_sticky_q <= oor_sticky_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // sample capture on the falling sample-clock edge
  always_comb begin
    pipe.shift = samp_fall;
    pipe.din.i = clamp_code(sync2_q[PIN_I_LSB +: CODE_W],
                            sync2_q[PIN_I_UNDER], sync2_q[PIN_I_OVER]);
    pipe.din.q = clamp_code(sync2_q[PIN_Q_LSB +: CODE_W],
                            sync2_q[PIN_Q_UNDER], sync2_q[PIN_Q_OVER]);
    pipe.din.oor = sync2_q[PIN_I_UNDER] | sync2_q[PIN_I_OVER] |
                   sync2_q[PIN_Q_UNDER] | sync2_q[PIN_Q_OVER];
  end

  // output formatter
  logic fclk_q, fclk_d, oe_q, oe_d, oor_q, oor_d;
  logic [CODE_W-1:0] ip_q, ip_d, qp_q, qp_d, id_q, id_d, qd_q, qd_d;
  logic range_q, range_d, swing_q, swing_d;
  logic [FS_ADJ_W-1:0] fs_code_q, fs_code_d;
  sample_word_t pt, dt;

  always_comb begin
    // one extra cycle of delay in demux DDR
    pt = ddr_demux ? pipe.tap_delayed : pipe.tap_primary;
    dt = ddr_demux ? pipe.tap_extra : pipe.tap_delayed;
    oor_set = word_ev & (pt.oor | (demux & dt.oor));
    phase_d = samp_fall ? ~phase_q : phase_q;
    ip_d = ip_q;
    qp_d = qp_q;
    id_d = id_q;
    qd_d = qd_q;
    oor_d = oor_q;
    fclk_d = fclk_q;
    oe_d = demux;
    if (word_ev) begin
      ip_d = pt.i;
      qp_d = pt.q;
      oor_d = pt.oor | (demux & dt.oor);
      id_d = demux ? dt.i : '0;
      qd_d = demux ? dt.q : '0;
      // DDR toggles with each word; SDR returns to the launch level
      fclk_d = ddr ? ~fclk_q : launch_rising;
    end else if (mid_ev) begin
      fclk_d = ~launch_rising;
    end
    range_d = sync2_q[PIN_RANGE];
    fs_code_d = reg_ctrl ? fs_adj_q
              : (sync2_q[PIN_RANGE] ? FS_PIN_HIGH_CODE : FS_PIN_LOW_CODE);
    swing_d = reg_ctrl ? cfg_q[CFG_SWING_BIT]
                       : sync2_q[PIN_SWING];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q <= 1'b0;
      fclk_q <= 1'b0;
      oe_q <= 1'b0;
      oor_q <= 1'b0;
      ip_q <= '0;
      qp_q <= '0;
      id_q <= '0;
      qd_q <= '0;
      range_q <= 1'b0;
      swing_q <= 1'b0;
      fs_code_q <= '0;
    end else begin
      phase_q <= phase_d;
      fclk_q <= fclk_d;
      oe_q <= oe_d;
      oor_q <= oor_d;
      ip_q <= ip_d;
      qp_q <= qp_d;
      id_q <= id_d;
      qd_q <= qd_d;
      range_q <= range_d;
      swing_q <= swing_d;
      fs_code_q <= fs_code_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign forwarded_output_clock_o = fclk_q;
  assign i_primary_bus_o = ip_q;
  assign q_primary_bus_o = qp_q;
  assign i_delayed_bus_o = id_q;
  assign q_delayed_bus_o = qd_q;
  assign delayed_bus_oe_o = oe_q;
  assign out_of_range_o = oor_q;
  assign range_high_o = range_q;
  assign full_scale_code_o = fs_code_q;
  assign swing_normal_o = swing_q;
  assign dcc_enable_o = cfg_q[CFG_DCC_BIT];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_primary_lat;
    word_ev && !ddr_demux |=> ip_q == $past(pipe.tap_primary.i);
  endproperty
  a_primary_lat: assert property (p_primary_lat)
    else $error("primary bus latency wrong");

  property p_delayed_lat;
    word_ev && demux && !ddr |=>
      id_q == $past(pipe.tap_delayed.i) && oe_q;
  endproperty
  a_delayed_lat: assert property (p_delayed_lat)
    else $error("delayed bus latency wrong");

  property p_nodemux_off;
    !demux |=> !oe_q;
  endproperty
  a_nodemux_off: assert property (p_nodemux_off)
    else $error("delayed bus driven in non-demux mode");

  property p_sdr_launch;
    word_ev && !ddr |=> fclk_q == $past(launch_rising);
  endproperty
  a_sdr_launch: assert property (p_sdr_launch)
    else $error("wrong SDR launch edge");

  property p_ddr_toggle;
    word_ev && ddr |=> fclk_q != $past(fclk_q);
  endproperty
  a_ddr_toggle: assert property (p_ddr_toggle)
    else $error("DDR clock did not toggle with data");

  property p_ddr_quiet;
    ddr && !word_ev |=> $stable(fclk_q);
  endproperty
  a_ddr_quiet: assert property (p_ddr_quiet)
    else $error("DDR clock moved between words");

  property p_ddr_extra;
    word_ev && ddr_demux |=> qp_q == $past(pipe.tap_delayed.q) &&
                              qd_q == $past(pipe.tap_extra.q);
  endproperty
  a_ddr_extra: assert property (p_ddr_extra)
    else $error("demux DDR extra cycle missing");

  property p_fs_reg;
    reg_ctrl ##1 reg_ctrl |-> fs_code_q == $past(fs_adj_q);
  endproperty
  a_fs_reg: assert property (p_fs_reg)
    else $error("full-scale code not from register");

  property p_swing;
    !reg_ctrl |=> swing_q == $past(sync2_q[PIN_SWING]);
  endproperty
  a_swing: assert property (p_swing)
    else $error("swing not following pin");

  property p_sdr_rate;
    word_ev && !ddr ##1 (!word_ev && !mid_ev) [*2] |-> $stable(fclk_q);
  endproperty
  a_sdr_rate: assert property (p_sdr_rate)
    else $error("SDR clock moved without an edge");

  c_demux_sdr: cover property (word_ev && demux && !ddr);
  c_nodemux_ddr: cover property (word_ev && !demux);
  c_demux_ddr: cover property (word_ev && ddr_demux);
  c_oor: cover property (oor_set);
endmodule
`default_nettype wire

// ### fwd_clock_receiver.sv
`default_nettype none
module fwd_clock_receiver (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic fclk_i,
  input wire logic [7:0] bus_i,
  output var logic [7:0] word_o,
  output var int rises_o,
  output var int chg_o,
  output var int chg_rise_o,
  output var int chg_edge_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fclk_q;
  logic [7:0] bus_q;
  // block outputs are clk_i registers: compare with the previous edge
  always @(posedge clk_i) begin
    if (fclk_i !== fclk_q) begin
      word_o <= bus_i;
    end
    if (clr_i) begin
      rises_o <= 0;
      chg_o <= 0;
      chg_rise_o <= 0;
      chg_edge_o <= 0;
    end else begin
      if (fclk_i && !fclk_q) begin
        rises_o <= rises_o + 1;
      end
      if (bus_i !== bus_q) begin
        chg_o <= chg_o + 1;
        if (fclk_i !== fclk_q) begin
          chg_edge_o <= chg_edge_o + 1;
        end
        if (fclk_i && !fclk_q) begin
          chg_rise_o <= chg_rise_o + 1;
        end
      end
    end
    fclk_q <= fclk_i;
    bus_q <= bus_i;
  end
endmodule
`default_nettype wire

// ### dual_adc_output_formatter_bench.sv
`default_nettype none
module dual_adc_output_formatter_bench import adc_fmt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, sample_clk_i, sclk;
  logic [APB_ADDR_W-1:0] paddr_i;
  logic [APB_DATA_W-1:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, i_under_i, i_over_i, q_under_i, q_over_i;
  logic launch_edge_select_pin_i, launch_edge_float_i, err, clr;
  logic range_select_pin_i, swing_select_pin_i, forwarded_output_clock_o;
  logic [CODE_W-1:0] i_code_i, q_code_i, i_primary_bus_o, q_primary_bus_o;
  logic [CODE_W-1:0] i_delayed_bus_o, q_delayed_bus_o, rx_word, falls;
  logic delayed_bus_oe_o, out_of_range_o, range_high_o;
  logic [FS_ADJ_W-1:0] full_scale_code_o;
  logic swing_normal_o, dcc_enable_o;
  int error_cnt, tests_run, rx_rises, rx_chg, rx_chg_rise, rx_chg_edge;

  dual_adc_output_formatter DUT (
    .clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sample_clk_i,
    .i_code_i, .q_code_i, .i_under_i, .i_over_i, .q_under_i, .q_over_i,
    .launch_edge_select_pin_i, .launch_edge_float_i, .range_select_pin_i,
    .swing_select_pin_i, .forwarded_output_clock_o, .i_primary_bus_o,
    .q_primary_bus_o, .i_delayed_bus_o, .q_delayed_bus_o,
    .delayed_bus_oe_o, .out_of_range_o, .range_high_o,
    .full_scale_code_o, .swing_normal_o, .dcc_enable_o
  );
  fwd_clock_receiver RX (
    .clk_i, .clr_i(clr), .fclk_i(forwarded_output_clock_o),
    .bus_i(i_primary_bus_o), .word_o(rx_word), .rises_o(rx_rises),
    .chg_o(rx_chg), .chg_rise_o(rx_chg_rise), .chg_edge_o(rx_chg_edge)
  );

  always #2.5 clk_i = ~clk_i;
  // link clock free of the system clock phase, resampled onto clk_i edges
  initial begin
    sclk = 1'b0;
    #7;
    forever #24 sclk = ~sclk;
  end
  always @(posedge clk_i) sample_clk_i <= sclk;
  always @(negedge sample_clk_i) falls <= falls + 8'h01;
  // codes move mid-period so they are settled at every fall
  always @(posedge sample_clk_i) begin
    i_code_i <= falls;
    q_code_i <= falls ^ 8'hA5;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      report_and_stop();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // sample at fall k carries code k-1, so primary lags the count by 14+lo, or 15+lo between demux words
  task automatic check_lat(input logic [7:0] lo, input logic oe);
    logic [7:0] e;
    @(posedge sample_clk_i);
    // one edge later: receiver may latch in the same step as the rise
    @(posedge clk_i);
    e = falls - 8'h0E - lo;
    if (oe && e - i_primary_bus_o == 8'h01) begin
      e = e - 8'h01;
    end
    chk("i_pri", i_primary_bus_o, e);
    chk("q_pri", q_primary_bus_o, e ^ 8'hA5);
    chk("i_dly", i_delayed_bus_o, oe ? e - 8'h01 : 8'h00);
    chk("q_dly", q_delayed_bus_o, oe ? (e - 8'h01) ^ 8'hA5 : 8'h00);
    chk("dly_oe", delayed_bus_oe_o, oe);
    chk("rx_word", rx_word, e);
  endtask

  task automatic run_mode(input logic [4:0] cfg, input logic [1:0] pins,
      input logic [7:0] lo, input logic oe, input int chg, input int rs,
      input int onr);
    apb(1'b1, CFG_OFFSET, {27'h0, cfg});
    launch_edge_select_pin_i <= pins[1];
    launch_edge_float_i <= pins[0];
    repeat (20) @(posedge sample_clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (16) check_lat(lo, oe);
    chk("fclk_rises", rx_rises, rs);
    chk("words", rx_chg, chg);
    chk("on_edge", rx_chg_edge, chg);
    chk("on_rise", rx_chg_rise, onr);
  endtask

  task automatic clamp(input logic [3:0] uo, input logic [7:0] ei,
      input logic [7:0] eq, input logic oor);
    {i_under_i, i_over_i, q_under_i, q_over_i} <= uo;
    repeat (20) @(posedge sample_clk_i);
    if (uo != 4'h0) begin
      chk("i_clamp", i_primary_bus_o, ei);
      chk("q_clamp", q_primary_bus_o, eq);
    end
    chk("oor", out_of_range_o, oor);
  endtask

  // watchdog: a stuck wait ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {clk_i, arst_n_i, psel_i, penable_i, pwrite_i, sample_clk_i} = '0;
    {i_under_i, i_over_i, q_under_i, q_over_i, clr} = '0;
    {launch_edge_select_pin_i, launch_edge_float_i} = '0;
    {range_select_pin_i, swing_select_pin_i} = '0;
    {paddr_i, pwdata_i, i_code_i, q_code_i, falls} = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("dcc", dcc_enable_o, 1'b1);
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg", rd, {27'h0, CFG_RESET});
    apb(1'b0, FS_ADJ_OFFSET, 32'h0);
    chk("fs_adj", rd, {23'h0, FS_ADJ_RESET});
    apb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    range_select_pin_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("range", range_high_o, 1'b1);
    chk("fs_pin", full_scale_code_o, FS_PIN_HIGH_CODE);
    chk("swing", swing_normal_o, 1'b0);
    range_select_pin_i <= 1'b0;
    swing_select_pin_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("range", range_high_o, 1'b0);
    chk("fs_pin", full_scale_code_o, FS_PIN_LOW_CODE);
    chk("swing", swing_normal_o, 1'b1);
    run_mode(5'h18, 2'b10, 8'h00, 1'b1, 8, 8, 8);
    run_mode(5'h18, 2'b00, 8'h00, 1'b1, 8, 8, 0);
    run_mode(5'h18, 2'b01, 8'h01, 1'b1, 8, 4, 4);
    run_mode(5'h05, 2'b00, 8'h00, 1'b1, 8, 8, 8);
    run_mode(5'h01, 2'b10, 8'h00, 1'b1, 8, 8, 0);
    range_select_pin_i <= 1'b1;
    apb(1'b1, FS_ADJ_OFFSET, 32'h0AB);
    repeat (3) @(posedge clk_i);
    chk("fs_reg", full_scale_code_o, 9'h0AB);
    chk("swing_reg", swing_normal_o, 1'b0);
    run_mode(5'h0B, 2'b00, 8'h01, 1'b1, 8, 4, 4);
    chk("swing_reg", swing_normal_o, 1'b1);
    run_mode(5'h07, 2'b00, 8'h00, 1'b0, 16, 8, 8);
    clamp(4'h9, CODE_MIN, CODE_MAX, 1'b1);
    clamp(4'h6, CODE_MAX, CODE_MIN, 1'b1);
    clamp(4'h0, CODE_MIN, CODE_MIN, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("sticky", rd[STAT_OOR_STICKY_BIT], 1'b1);
    apb(1'b1, STATUS_OFFSET, 32'h10);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("sticky_clr", rd[STAT_OOR_STICKY_BIT], 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
